/* File: bewls_pkg.sv */
`default_nettype none
package bewls_pkg;

  // ---------------------------------------------------------------
  // Transfer size codes and external bus widths
  // ---------------------------------------------------------------
  localparam logic [2:0] SIZE_BYTE = 3'h0;
  localparam logic [2:0] SIZE_HALF = 3'h1;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // ---------------------------------------------------------------
  // Bus codes and reset values
  // ---------------------------------------------------------------
  localparam int         HTRANS_ACTIVE_BIT = 1;
  localparam logic [1:0] HRESP_OKAY        = 2'h0;
  localparam logic [1:0] HRESP_ERROR       = 2'h1;
  localparam logic [3:0] BLS_NONE          = 4'hf;
  localparam logic [3:0] BLS_ALL           = 4'h0;
  localparam logic [3:0] BLS_LOW_HALF      = 4'hc;
  localparam logic [3:0] BLS_HIGH_HALF     = 4'h3;
  localparam logic [3:0] BLS_NARROW8       = 4'he;
  localparam logic [1:0] BLS16_ODD_BYTE    = 2'h2;
  localparam logic [1:0] BLS16_EVEN_BYTE   = 2'h1;

  typedef struct packed {
    logic [1:0] width;
    logic [2:0] size;
    logic [1:0] addr;
  } bewls_ctx_t;

  typedef struct packed {
    logic [1:0]  addr;
    logic [3:0]  bls;
    logic [31:0] data;
  } bewls_beat_t;

  localparam bewls_beat_t BEAT_IDLE = '{addr: 2'h0, bls: BLS_NONE, data: 32'h0};

  // Index of the final external transfer of an access.
  function automatic logic [1:0] bewls_last_beat(input bewls_ctx_t c);
    logic [1:0] diff;
    diff = c.size[1:0] - c.width;
    if (c.size[1:0] <= c.width) begin
      return 2'h0;
    end
    return (diff == 2'h2) ? 2'h3 : 2'h1;
  endfunction

endpackage
`default_nettype wire

/* File: bewls_lane_map.sv */
`timescale 1ns/10ps
`default_nettype none
module bewls_lane_map #(
  parameter int DATA_W = 32
) (
  // Access context
  input  wire bewls_pkg::bewls_ctx_t  ctx,
  input  wire logic [1:0]             beat,
  input  wire logic [DATA_W-1:0]      data,
  // Steered transfer
  output bewls_pkg::bewls_beat_t      out
);

  if (DATA_W != 32) begin : g_width_check
    $error("bewls_lane_map serves a 32-bit system bus only");
  end

  logic [1:0]  a8;
  logic        a16;
  logic [15:0] half16;

  always_comb begin
    out = bewls_pkg::BEAT_IDLE;
    a8 = ctx.addr;
    if (ctx.size == bewls_pkg::SIZE_WORD) begin
      a8 = 2'h3 - beat; // RULE1 RULE9
    end else if (ctx.size == bewls_pkg::SIZE_HALF) begin
      a8 = {ctx.addr[1], ~beat[0]}; // RULE2 RULE9
    end
    a16 = (ctx.size == bewls_pkg::SIZE_WORD) ? ~beat[0] : ctx.addr[1]; // RULE3
    half16 = a16 ? data[15:0] : data[31:16];
    unique case (ctx.width)
      bewls_pkg::WIDTH_8: begin
        out.addr = a8;
        out.bls  = bewls_pkg::BLS_NARROW8; // RULE2
        out.data = {24'h0, 8'(data >> {~a8, 3'h0})}; // RULE1
      end
      bewls_pkg::WIDTH_16: begin
        out.addr = {1'b0, a16};
        out.data = {16'h0, half16}; // RULE3 RULE4
        if (ctx.size == bewls_pkg::SIZE_BYTE) begin
          out.bls = {2'h3, ctx.addr[0] ? bewls_pkg::BLS16_ODD_BYTE
                                       : bewls_pkg::BLS16_EVEN_BYTE}; // RULE4
        end else begin
          out.bls = bewls_pkg::BLS_LOW_HALF;
        end
      end
      default: begin
        out.addr = 2'h0;
        out.data = data; // RULE5
        if (ctx.size == bewls_pkg::SIZE_WORD) begin
          out.bls = bewls_pkg::BLS_ALL;
        end else if (ctx.size == bewls_pkg::SIZE_HALF) begin
          out.bls = ctx.addr[1] ? bewls_pkg::BLS_LOW_HALF : bewls_pkg::BLS_HIGH_HALF; // RULE5
        end else begin
          out.bls = ~(4'h1 << ~ctx.addr); // RULE6
        end
      end
    endcase
  end

endmodule // bewls_lane_map
`default_nettype wire

/* File: bewls_top.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// [RULE1] On an 8-bit bus a word write becomes four byte transfers at low addresses 11 to 00.
// [RULE2] On an 8-bit bus a halfword is two byte transfers and a byte one, lane select low.
// [RULE3] On a 16-bit bus a word is two halfword transfers, selects 00, halfword picks one.
// [RULE4] On a 16-bit bus a byte goes on the lane of its address with selects 10 or 01.
// [RULE5] On a 32-bit bus every write is one transfer; a word or halfword selects 0000, 1100 or 0011.
// [RULE6] On a 32-bit bus a byte write selects 1110, 1101, 1011 or 0111 by its address.
// [RULE7] The system bus is stalled until every external transfer of an access is done.
// [RULE8] Any access wider than a word gets an error response and is not performed.
// [RULE9] Split transfers go out from the highest low address down; select low is active.
module bewls_top #(
  parameter int DATA_W = 32
) (
  // Clock and reset
  input  wire  logic              core_clk,
  input  wire  logic              reset_n,
  // System bus slave
  input  wire  logic              hsel,
  input  wire  logic [1:0]        htrans,
  input  wire  logic              hwrite,
  input  wire  logic [2:0]        hsize,
  input  wire  logic [1:0]        haddr,
  input  wire  logic [DATA_W-1:0] hwdata,
  input  wire  logic              hready_in,
  output logic                    hreadyout,
  output logic [1:0]              hresp,
  // Width of the selected memory
  input  wire  logic [1:0]        mem_width,
  // External memory side
  output logic                    ext_req,
  input  wire  logic              ext_ack,
  output logic [1:0]              ext_addr_out,
  output logic [3:0]              byte_lane_select_out,
  output logic [DATA_W-1:0]       ext_data_out
);

  if (DATA_W != 32) begin : g_width_check
    $error("bewls_top serves a 32-bit system bus only");
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOAD = 3'h1,
    ST_XFER = 3'h3,
    ST_ERR1 = 3'h2,
    ST_ERR2 = 3'h6
  } bewls_state_t;

  bewls_state_t           state;
  bewls_state_t           next_state;
  bewls_pkg::bewls_ctx_t  ctx;
  bewls_pkg::bewls_ctx_t  next_ctx;
  logic [DATA_W-1:0]      wdata;
  logic [DATA_W-1:0]      next_wdata;
  logic [1:0]             beat;
  logic [1:0]             next_beat;
  bewls_pkg::bewls_beat_t out;
  bewls_pkg::bewls_beat_t next_out;
  bewls_pkg::bewls_beat_t mapped;
  logic [1:0]             map_beat;
  logic [DATA_W-1:0]      map_data;
  logic                   last;
  logic                   accept;
  logic                   oversize;

  assign last     = (beat == bewls_pkg::bewls_last_beat(ctx));
  assign oversize = (hsize > bewls_pkg::SIZE_WORD);
  assign accept   = hsel && htrans[bewls_pkg::HTRANS_ACTIVE_BIT] && hready_in && hreadyout;

  // The data phase holds the bus until the final beat is acknowledged.
  assign ext_req   = (state == ST_XFER);
  assign hreadyout = (state == ST_IDLE) || (state == ST_ERR2)
                   || (ext_req && ext_ack && last); // RULE7
  assign hresp     = (state == ST_ERR1 || state == ST_ERR2) ? bewls_pkg::HRESP_ERROR
                                                             : bewls_pkg::HRESP_OKAY; // RULE8

  assign ext_addr_out         = out.addr;
  assign byte_lane_select_out = out.bls;
  assign ext_data_out         = out.data;

  // The first beat is mapped straight from the write data so it leaves a cycle earlier.
  assign map_beat = (state == ST_LOAD) ? 2'h0 : beat + 2'h1;
  assign map_data = (state == ST_LOAD) ? hwdata : wdata;

  bewls_lane_map #(
    .DATA_W (DATA_W)
  ) u_lane_map (
    .ctx  (ctx),
    .beat (map_beat),
    .data (map_data),
    .out  (mapped)
  );

  always_comb begin
    next_state = state;
    next_ctx   = ctx;
    next_wdata = wdata;
    next_beat  = beat;
    next_out   = out;
    unique case (state)
      ST_IDLE: begin
        next_state = ST_IDLE;
      end
      ST_LOAD: begin
        next_wdata = hwdata;
        next_beat  = 2'h0;
        next_out   = mapped;
        next_state = ST_XFER;
      end
      ST_XFER: begin
        if (ext_ack) begin
          if (last) begin
            next_out   = bewls_pkg::BEAT_IDLE;
            next_state = ST_IDLE;
          end else begin
            next_beat = beat + 2'h1; // RULE7 RULE9
            next_out  = mapped;
          end
        end
      end
      ST_ERR1: begin
        next_state = ST_ERR2;
      end
      ST_ERR2: begin
        next_state = ST_IDLE;
      end
    endcase
    if (accept) begin
      if (oversize) begin
        next_state = ST_ERR1; // RULE8
      end else if (hwrite) begin
        next_ctx.width = (mem_width > bewls_pkg::WIDTH_32) ? bewls_pkg::WIDTH_32 : mem_width;
        next_ctx.size  = hsize;
        next_ctx.addr  = haddr;
        next_state     = ST_LOAD;
      end else begin
        next_state = ST_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      ctx   <= '{width: bewls_pkg::WIDTH_32, size: bewls_pkg::SIZE_WORD, addr: 2'h0};
      wdata <= '0;
      beat  <= 2'h0;
      out   <= bewls_pkg::BEAT_IDLE;
    end else begin
      state <= next_state;
      ctx   <= next_ctx;
      wdata <= next_wdata;
      beat  <= next_beat;
      out   <= next_out;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  word8_lane_a: assert property ( // RULE1
    ext_req && ctx.width == bewls_pkg::WIDTH_8 && ctx.size == bewls_pkg::SIZE_WORD
    |-> ext_addr_out == ~beat && ext_data_out[7:0] == 8'(wdata >> {beat, 3'h0})
  ) else $error("8-bit word beat carries the wrong byte");

  narrow8_sel_a: assert property ( // RULE2
    ext_req && ctx.width == bewls_pkg::WIDTH_8 && ctx.size != bewls_pkg::SIZE_WORD
    |-> ext_addr_out[1] == ctx.addr[1] && byte_lane_select_out[0] == 1'b0
  ) else $error("8-bit halfword or byte beat is misplaced");

  half16_map_a: assert property ( // RULE3
    ext_req && ctx.width == bewls_pkg::WIDTH_16 && ctx.size != bewls_pkg::SIZE_BYTE
    |-> byte_lane_select_out[1:0] == 2'h0
        && ext_data_out[15:0] == (ext_addr_out[0] ? wdata[15:0] : wdata[31:16])
  ) else $error("16-bit halfword beat is wrong");

  byte16_sel_a: assert property ( // RULE4
    ext_req && ctx.width == bewls_pkg::WIDTH_16 && ctx.size == bewls_pkg::SIZE_BYTE
    |-> byte_lane_select_out[1:0] == (ctx.addr[0] ? 2'h2 : 2'h1)
        && ext_addr_out[0] == ctx.addr[1] && last
  ) else $error("16-bit byte beat uses the wrong lane");

  single32_a: assert property ( // RULE5
    ext_req && ctx.width == bewls_pkg::WIDTH_32 && ctx.size != bewls_pkg::SIZE_BYTE
    |-> last && ext_data_out == wdata
        && byte_lane_select_out == (ctx.size == bewls_pkg::SIZE_WORD ? 4'h0
                                    : (ctx.addr[1] ? 4'hc : 4'h3))
  ) else $error("32-bit word or halfword transfer is wrong");

  byte32_sel_a: assert property ( // RULE6
    ext_req && ctx.width == bewls_pkg::WIDTH_32 && ctx.size == bewls_pkg::SIZE_BYTE
    |-> $countones(byte_lane_select_out) == 3 && !byte_lane_select_out[~ctx.addr]
  ) else $error("32-bit byte write selects the wrong lane");

  bus_stall_a: assert property ( // RULE7
    (state == ST_LOAD) || (ext_req && !(ext_ack && last)) |-> !hreadyout
  ) else $error("system bus released before the last transfer");

  stall_bound_a: assert property ( // RULE7
    ext_req && ext_ack && last |-> hreadyout ##1 !ext_req || state == ST_LOAD
  ) else $error("final acknowledge did not complete the access");

  oversize_err_a: assert property ( // RULE8
    accept && oversize
    |=> !hreadyout && hresp == 2'h1 && !ext_req ##1 hreadyout && hresp == 2'h1
  ) else $error("oversize access not answered with a two-cycle error");

  down_order_a: assert property ( // RULE9
    ext_req && ext_ack && !last && ctx.width != bewls_pkg::WIDTH_32
    |=> ext_req && ext_addr_out == $past(ext_addr_out) - 2'h1
  ) else $error("split transfers not issued from the highest address down");

  word8_done_c: cover property (
    ext_req && ext_ack && last && ctx.width == bewls_pkg::WIDTH_8
    && ctx.size == bewls_pkg::SIZE_WORD
  );
  byte16_done_c: cover property (
    ext_req && ext_ack && ctx.width == bewls_pkg::WIDTH_16 && ctx.size == bewls_pkg::SIZE_BYTE
  );
  error_resp_c: cover property (state == ST_ERR2);
  back_to_back_c: cover property (ext_req && ext_ack && last ##1 state == ST_LOAD);

endmodule // bewls_top
`default_nettype wire

/* File: bewls_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bewls_mem_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Transfer handshake
  input  wire logic       ext_req,
  input  wire logic [1:0] wait_cycles,
  output logic            ext_ack
);
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  // A slow device holds off each beat; a count of zero answers at once.
  assign ext_ack = ext_req && (cnt >= wait_cycles);
  always_comb begin
    next_cnt = (ext_req && !ext_ack) ? cnt + 2'h1 : 2'h0;
  end
  always_ff @(posedge core_clk) begin
    cnt <= reset_n ? next_cnt : 2'h0;
  end
endmodule // bewls_mem_model
`default_nettype wire

/* File: big_endian_write_lane_steering_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module big_endian_write_lane_steering_tb;
  logic core_clk, reset_n, hsel, hwrite, hreadyout, ext_req, ext_ack;
  logic [1:0] htrans, haddr, hresp, mem_width, ext_addr_out, wait_cycles;
  logic [2:0] hsize;
  logic [3:0] byte_lane_select_out;
  logic [31:0] hwdata, ext_data_out;
  int n_fail, n_checks, cyc, seed;

  bewls_top dut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .haddr(haddr), .hwdata(hwdata), .hready_in(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .mem_width(mem_width), .ext_req(ext_req),
    .ext_ack(ext_ack), .ext_addr_out(ext_addr_out),
    .byte_lane_select_out(byte_lane_select_out), .ext_data_out(ext_data_out));
  bewls_mem_model mem (.core_clk(core_clk), .reset_n(reset_n), .ext_req(ext_req),
    .wait_cycles(wait_cycles), .ext_ack(ext_ack));

  // ---------------------------------------------------------------
  // Expected transfers
  // ---------------------------------------------------------------
  function automatic int n_beats(input logic [1:0] w, input logic [2:0] s);
    if (w == 2'h0) return (s == 3'h2) ? 4 : (s == 3'h1) ? 2 : 1;
    if (w == 2'h1) return (s == 3'h2) ? 2 : 1;
    return 1;
  endfunction

  function automatic bewls_pkg::bewls_beat_t exp_beat(input logic [1:0] w,
      input logic [2:0] s, input logic [1:0] a, input logic [31:0] d, input int i);
    bewls_pkg::bewls_beat_t b;
    logic [1:0] ad;
    int sh;
    b = '{addr: 2'h0, bls: 4'hf, data: 32'h0};
    sh = 3 - int'(a);
    if (w == 2'h0) begin
      ad = (s == 3'h2) ? 2'h3 : (s == 3'h1) ? {a[1], 1'b1} : a;
      ad = ad - 2'(i);
      b.addr = ad;
      b.bls = 4'he;
      b.data = {24'h0, d[8*(3-int'(ad)) +: 8]};
    end else if (w == 2'h1) begin
      // The whole selected halfword goes out; the lane selects mark the live byte.
      b.addr = (s == 3'h2) ? 2'(1 - i) : {1'b0, a[1]};
      b.data = {16'h0, b.addr[0] ? d[15:0] : d[31:16]};
      if (s == 3'h0) begin
        b.bls = a[0] ? 4'he : 4'hd;
      end else begin
        b.bls = 4'hc;
      end
    end else begin
      // Lanes match system bit positions, so the full word is presented.
      b.data = d;
      if (s == 3'h2) begin
        b.bls = 4'h0;
      end else if (s == 3'h1) begin
        b.bls = a[1] ? 4'hc : 4'h3;
      end else begin
        b.bls = ~(4'h1 << sh);
      end
    end
    return b;
  endfunction

  // ---------------------------------------------------------------
  // Bus access and beat checking
  // ---------------------------------------------------------------
  task automatic acc(input logic [1:0] w, input logic [2:0] s, input logic [1:0] a,
      input logic hw, input logic [31:0] d);
    int nb, k, t;
    bewls_pkg::bewls_beat_t e, g;
    nb = n_beats(w, s);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= hw;
    hsize <= s;
    haddr <= a;
    mem_width <= w;
    wait_cycles <= 2'($urandom_range(0, 3));
    @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (s > 3'h2) begin
      @(negedge core_clk);
      `CHK("err1", 3'h1, {hreadyout, hresp})
      @(negedge core_clk);
      `CHK("err2", 4'ha, {hreadyout, hresp, ext_req})
      return;
    end
    if (!hw) begin
      @(negedge core_clk);
      `CHK("read", 2'h2, {hreadyout, ext_req})
      return;
    end
    k = 0;
    t = 0;
    while (k < nb && t < 100) begin
      @(negedge core_clk);
      t++;
      if (ext_req && ext_ack) begin
        e = exp_beat(w, s, a, d, k);
        g = {ext_addr_out, byte_lane_select_out, ext_data_out};
        if (w == 2'h0) `CHK("beat8", e, g)
        else if (w == 2'h1) `CHK("beat16", e, g)
        else `CHK("beat32", e, g)
        `CHK("done", {k == nb - 1, 2'h0}, {hreadyout, hresp})
        k++;
      end else `CHK("stall", 1'b0, hreadyout)
    end
    if (t >= 100) `CHK("beats", nb, k)
    @(negedge core_clk);
    `CHK("idle", 6'h2f, {hreadyout, ext_req, byte_lane_select_out})
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // A hang in the handshake is cut short well past the longest expected run.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    seed = $urandom(32'h6f7cde5f);
    {reset_n, hsel, hwrite, htrans, haddr, hsize, mem_width, wait_cycles} = '0;
    hwdata = 32'h0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    `CHK("reset", 8'h8f, {hreadyout, hresp, ext_req, byte_lane_select_out})
    `CHK("reset_data", 34'h0, {ext_addr_out, ext_data_out})
    for (int w = 0; w < 3; w++)
      for (int s = 0; s < 3; s++)
        for (int a = 0; a < 4; a++) acc(2'(w), 3'(s), 2'(a), 1'b1, $urandom);
    for (int s = 3; s < 8; s++) acc(2'($urandom), 3'(s), 2'($urandom), 1'b1, $urandom);
    acc(2'h0, 3'h2, 2'h0, 1'b0, $urandom);
    repeat (80) acc(2'($urandom), 3'($urandom_range(0, 2)), 2'($urandom), 1'b1, $urandom);
    tally_and_finish();
  end
endmodule // big_endian_write_lane_steering_tb
`undef CHK
`default_nettype wire
